// *** rsc_reset_combiner.v ***
// reset source combiner with cause flags on apb
//
// Summary of operation
// - all seven reset sources merge into one master reset output.
// - master reset is asserted whenever any source is active.
// - each reset source sets its own dedicated cause flag.
// - power-on reset clears all cause flags, then sets the power-on flag.
// - software may write any cause flag to one, or to zero unless its source sets it that cycle.
// - writing a cause flag only stores status, never causes a reset.
// - while a non-power-on master reset is asserted, only the software reset request takes its reset value.
// - registers without reset value keep contents through non-power-on resets.
`timescale 1ns/1ps
`include "rsc_consts.vh"
module rsc_reset_combiner (
  input wire clk_sys,
  input wire rst_b,
  input wire brown_out_reset,
  input wire external_clear_pin_reset,
  input wire software_reset_instruction,
  input wire watchdog_timeout_reset,
  input wire trap_conflict_reset,
  input wire illegal_opcode_reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire master_reset_signal,
  output wire irq
);
  // ==========================================================
  // source merge
  wire por_active;
  wire [`RSC_NUM_CAUSE-1:0] src;
  wire any_src;
  reg sw_reset_req;
  assign por_active = ~rst_b;
  assign src[`RSC_BIT_POR] = 1'b0;
  assign src[`RSC_BIT_BROWN] = brown_out_reset;
  assign src[`RSC_BIT_PIN] = external_clear_pin_reset;
  assign src[`RSC_BIT_SOFT] = software_reset_instruction | sw_reset_req;
  assign src[`RSC_BIT_WATCHDOG] = watchdog_timeout_reset;
  assign src[`RSC_BIT_TRAP] = trap_conflict_reset;
  assign src[`RSC_BIT_IOP] = illegal_opcode_reset;
  assign any_src = |src;
  assign master_reset_signal = por_active | any_src;

  // ==========================================================
  // apb decode
  wire wr_en;
  wire mapped;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign mapped = (paddr == `RSC_ADDR_CAUSE) | (paddr == `RSC_ADDR_IRQ_STATUS) |
                  (paddr == `RSC_ADDR_IRQ_CLEAR) | (paddr == `RSC_ADDR_IRQ_ENABLE) |
                  (paddr == `RSC_ADDR_SW_RESET) | (paddr == `RSC_ADDR_KEEP);
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // cause flags, reset only by power-on, also cleared by software writes
  wire [`RSC_NUM_CAUSE-1:0] cause;
  wire cause_wr;
  assign cause_wr = wr_en & (paddr == `RSC_ADDR_CAUSE);
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_SET)
  ) u_cause_por (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src[`RSC_BIT_POR]),
    .load(cause_wr),
    .load_value(pwdata[`RSC_BIT_POR]),
    .flag(cause[`RSC_BIT_POR])
  );
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_cause_brown (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src[`RSC_BIT_BROWN]),
    .load(cause_wr),
    .load_value(pwdata[`RSC_BIT_BROWN]),
    .flag(cause[`RSC_BIT_BROWN])
  );
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_cause_pin (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src[`RSC_BIT_PIN]),
    .load(cause_wr),
    .load_value(pwdata[`RSC_BIT_PIN]),
    .flag(cause[`RSC_BIT_PIN])
  );
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_cause_soft (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src[`RSC_BIT_SOFT]),
    .load(cause_wr),
    .load_value(pwdata[`RSC_BIT_SOFT]),
    .flag(cause[`RSC_BIT_SOFT])
  );
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_cause_watchdog (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src[`RSC_BIT_WATCHDOG]),
    .load(cause_wr),
    .load_value(pwdata[`RSC_BIT_WATCHDOG]),
    .flag(cause[`RSC_BIT_WATCHDOG])
  );
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_cause_trap (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src[`RSC_BIT_TRAP]),
    .load(cause_wr),
    .load_value(pwdata[`RSC_BIT_TRAP]),
    .flag(cause[`RSC_BIT_TRAP])
  );
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_cause_iop (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src[`RSC_BIT_IOP]),
    .load(cause_wr),
    .load_value(pwdata[`RSC_BIT_IOP]),
    .flag(cause[`RSC_BIT_IOP])
  );

  // ==========================================================
  // interrupt status on new cause events
  reg [`RSC_NUM_CAUSE-1:0] src_q;
  wire [`RSC_NUM_CAUSE-1:0] irq_status;
  reg [`RSC_NUM_CAUSE-1:0] irq_enable;
  wire [`RSC_NUM_CAUSE-1:0] src_rise;
  wire [`RSC_NUM_CAUSE-1:0] clr_mask;
  assign src_rise = src & ~src_q;
  assign clr_mask = (wr_en && paddr == `RSC_ADDR_IRQ_CLEAR) ?
                    pwdata[`RSC_NUM_CAUSE-1:0] : `RSC_ZERO7;
  // edge history and enable mask
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      src_q <= `RSC_ZERO7;
      irq_enable <= `RSC_ZERO7;
    end else begin
      src_q <= src;
      if (wr_en && paddr == `RSC_ADDR_IRQ_ENABLE) begin
        irq_enable <= pwdata[`RSC_NUM_CAUSE-1:0];
      end
    end
  end
  // status cells survive functional resets; set beats clear
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_stat_por (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src_rise[`RSC_BIT_POR]),
    .load(clr_mask[`RSC_BIT_POR]),
    .load_value(`RSC_FLAG_CLR),
    .flag(irq_status[`RSC_BIT_POR])
  );
  // brown-out event status
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_stat_brown (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src_rise[`RSC_BIT_BROWN]),
    .load(clr_mask[`RSC_BIT_BROWN]),
    .load_value(`RSC_FLAG_CLR),
    .flag(irq_status[`RSC_BIT_BROWN])
  );
  // clear pin event status
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_stat_pin (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src_rise[`RSC_BIT_PIN]),
    .load(clr_mask[`RSC_BIT_PIN]),
    .load_value(`RSC_FLAG_CLR),
    .flag(irq_status[`RSC_BIT_PIN])
  );
  // software reset event status
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_stat_soft (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src_rise[`RSC_BIT_SOFT]),
    .load(clr_mask[`RSC_BIT_SOFT]),
    .load_value(`RSC_FLAG_CLR),
    .flag(irq_status[`RSC_BIT_SOFT])
  );
  // watchdog event status
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_stat_watchdog (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src_rise[`RSC_BIT_WATCHDOG]),
    .load(clr_mask[`RSC_BIT_WATCHDOG]),
    .load_value(`RSC_FLAG_CLR),
    .flag(irq_status[`RSC_BIT_WATCHDOG])
  );
  // trap conflict event status
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_stat_trap (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src_rise[`RSC_BIT_TRAP]),
    .load(clr_mask[`RSC_BIT_TRAP]),
    .load_value(`RSC_FLAG_CLR),
    .flag(irq_status[`RSC_BIT_TRAP])
  );
  // illegal opcode event status
  rsc_flag_cell #(
    .RESET_VALUE(`RSC_FLAG_CLR)
  ) u_stat_iop (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_evt(src_rise[`RSC_BIT_IOP]),
    .load(clr_mask[`RSC_BIT_IOP]),
    .load_value(`RSC_FLAG_CLR),
    .flag(irq_status[`RSC_BIT_IOP])
  );
  assign irq = |(irq_status & irq_enable);

  // ==========================================================
  // software reset request and scratch register
  reg [15:0] keep_data;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sw_reset_req <= 1'b0;
    end else if (master_reset_signal) begin
      sw_reset_req <= 1'b0;
    end else if (wr_en && paddr == `RSC_ADDR_SW_RESET) begin
      sw_reset_req <= pwdata[0];
    end
  end
  // no reset term, kept through all resets
  always @(posedge clk_sys) begin
    if (wr_en && paddr == `RSC_ADDR_KEEP) begin
      keep_data <= pwdata[15:0];
    end
  end

  // ==========================================================
  // read data
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= `RSC_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `RSC_ADDR_CAUSE: prdata <= {25'h0000000, cause};
        `RSC_ADDR_IRQ_STATUS: prdata <= {25'h0000000, irq_status};
        `RSC_ADDR_IRQ_ENABLE: prdata <= {25'h0000000, irq_enable};
        `RSC_ADDR_KEEP: prdata <= {`RSC_ZERO16, keep_data};
        default: prdata <= `RSC_ZERO32;
      endcase
    end
  end
endmodule

// ==========================================================
// one sticky flag: hardware set wins over a load in the same cycle
module rsc_flag_cell #(
  parameter RESET_VALUE = 1'b0
) (
  input wire clk_sys,
  input wire rst_b,
  input wire set_evt,
  input wire load,
  input wire load_value,
  output reg flag
);
  reg next_flag;
  // load first, then set on top
  always @* begin
    next_flag = flag;
    if (load) begin
      next_flag = load_value;
    end
    if (set_evt) begin
      next_flag = `RSC_FLAG_SET;
    end
  end
  // only power-on applies RESET_VALUE; otherwise the flag follows next_flag each clock
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag <= RESET_VALUE;
    end else begin
      flag <= next_flag;
    end
  end
endmodule

// *** rsc_consts.vh ***
// constants for the reset source combiner
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// apb byte addresses
`define RSC_ADDR_CAUSE 12'h000
`define RSC_ADDR_IRQ_STATUS 12'h004
`define RSC_ADDR_IRQ_CLEAR 12'h008
`define RSC_ADDR_IRQ_ENABLE 12'h00C
`define RSC_ADDR_SW_RESET 12'h010
`define RSC_ADDR_KEEP 12'h014
// cause flag positions
`define RSC_BIT_POR 0
`define RSC_BIT_BROWN 1
`define RSC_BIT_PIN 2
`define RSC_BIT_SOFT 3
`define RSC_BIT_WATCHDOG 4
`define RSC_BIT_TRAP 5
`define RSC_BIT_IOP 6
`define RSC_NUM_CAUSE 7
// reset values
`define RSC_CAUSE_POR_VALUE 7'h01
`define RSC_ZERO7 7'h00
`define RSC_ZERO32 32'h00000000
`define RSC_ZERO16 16'h0000
// single flag levels
`define RSC_FLAG_SET 1'b1
`define RSC_FLAG_CLR 1'b0
`endif

// *** rsc_sva.sv ***
// port assertions for the reset source combiner
`timescale 1ns/1ps
module rsc_sva (input logic clk_sys, rst_b, brown_out_reset, external_clear_pin_reset,
  software_reset_instruction, watchdog_timeout_reset, trap_conflict_reset,
  illegal_opcode_reset, psel, penable, pwrite, pready, pslverr, master_reset_signal, irq,
  input logic [11:0] paddr, input logic [31:0] prdata);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire [5:0] src = {brown_out_reset, external_clear_pin_reset, software_reset_instruction,
    watchdog_timeout_reset, trap_conflict_reset, illegal_opcode_reset};
  wire rd_set = psel && !penable && !pwrite;
  wire acc = psel && penable;
  src_merge_a: assert property (|src |-> master_reset_signal) else $error("merge");
  rst_end_a: assert property ($fell(master_reset_signal) |-> !(|src)) else $error("end");
  wr_quiet_a: assert property (acc && pwrite && paddr == 12'h000 && !master_reset_signal
    |=> !master_reset_signal || |src) else $error("write reset");
  bo_flag_a: assert property (brown_out_reset ##1 (rd_set && paddr == 12'h000)
    |=> prdata[1]) else $error("bo flag");
  iop_flag_a: assert property (illegal_opcode_reset ##1 (rd_set && paddr == 12'h000)
    |=> prdata[6]) else $error("iop flag");
  zero_wait_a: assert property (acc |-> pready) else $error("wait");
  bad_addr_a: assert property (acc && paddr == 12'h018 |-> pslverr) else $error("slverr");
  irq_idle_a: assert property ($rose(rst_b) |-> !irq) else $error("irq");
endmodule
bind rsc_reset_combiner rsc_sva u_sva (.*);

// *** rsc_src_model.sv ***
// model of the six on-chip reset sources
`timescale 1ns/1ps
module rsc_src_model (input logic clk_sys, input logic [5:0] req, output logic [5:0] src);
  initial src = 6'h00;
  // sources are synchronous active high levels
  always @(posedge clk_sys) src <= req;
endmodule

// *** test_reset_source_combiner.sv ***
// self-checking bench for the reset source combiner
`timescale 1ns/1ps
`include "rsc_consts.vh"
module test_reset_source_combiner;
  logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q[$];
  logic [5:0] req = 6'h00, src;
  logic pready, pslverr, master_reset_signal, irq;
  int err_count = 0, check_count = 0;
  always #4 clk_sys = ~clk_sys;
  rsc_src_model u_src (.clk_sys(clk_sys), .req(req), .src(src));
  rsc_reset_combiner dut (.clk_sys(clk_sys), .rst_b(rst_b), .brown_out_reset(src[5]),
    .external_clear_pin_reset(src[4]), .software_reset_instruction(src[3]),
    .watchdog_timeout_reset(src[2]), .trap_conflict_reset(src[1]), .illegal_opcode_reset(src[0]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_reset_signal(master_reset_signal), .irq(irq));
  task automatic chk(input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR value expected %h seen %h", e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  // pulse source i (cause bit i+1) for one cycle
  task automatic pulse(input int i);
    @(posedge clk_sys) req <= 6'h20 >> i;
    @(posedge clk_sys) req <= 6'h00;
    @(negedge clk_sys) chk(32'h1, {31'h0, master_reset_signal});
  endtask
  // scoreboard: oldest note against read data at the access edge
  always @(posedge clk_sys) if (psel && penable && !pwrite && q.size() > 0) chk(q.pop_front(), prdata);
  always @(posedge clk_sys) if (psel && penable && paddr == 12'h018) chk(32'h1, {31'h0, pslverr});
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin #100000; err_count++; give_verdict; end
  initial begin
    logic [31:0] v;
    void'($urandom(32'hBEE9));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1;
    rd(`RSC_ADDR_CAUSE, 32'h1);
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      rd(`RSC_ADDR_CAUSE, (32'h4 << i) - 32'h1);
    end
    v = $urandom & 32'hFFFF;
    apb(1, `RSC_ADDR_KEEP, v);
    pulse(3);
    rd(`RSC_ADDR_KEEP, v);
    v = $urandom & 32'h7F;
    apb(1, `RSC_ADDR_CAUSE, v);
    rd(`RSC_ADDR_CAUSE, v);
    apb(1, `RSC_ADDR_CAUSE, 32'h0);
    apb(1, `RSC_ADDR_IRQ_ENABLE, 32'h2);
    apb(1, `RSC_ADDR_IRQ_CLEAR, 32'h7F);
    pulse(1);
    rd(`RSC_ADDR_IRQ_STATUS, 32'h4);
    chk(32'h0, {31'h0, irq});
    pulse(0);
    rd(`RSC_ADDR_IRQ_STATUS, 32'h6);
    rd(`RSC_ADDR_CAUSE, 32'h6);
    chk(32'h1, {31'h0, irq});
    apb(1, `RSC_ADDR_IRQ_CLEAR, 32'h2);
    rd(12'h018, 32'h0);
    chk(32'h0, {31'h0, irq});
    @(posedge clk_sys) rst_b <= 0;
    @(posedge clk_sys) rst_b <= 1;
    rd(`RSC_ADDR_CAUSE, 32'h1);
    @(negedge clk_sys) chk(32'h0, {31'h0, master_reset_signal});
    give_verdict;
  end
endmodule
